// file: common/two_wire_if.sv
`timescale 1ns/1ps
interface two_wire_if;
    logic scl_o;
    logic scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl_line;
    logic sda_line;

    // pull-up: a line is low only while some party enables a low drive
    assign scl_line = scl_oe_n | scl_o;
    assign sda_line = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

    modport device (
        input scl_line,
        input sda_line,
        output d_sda_o,
        output d_sda_oe_n
    );

    modport master (
        input scl_line,
        input sda_line,
        output scl_o,
        output scl_oe_n,
        output m_sda_o,
        output m_sda_oe_n
    );
endinterface

// file: common/two_wire_params.svh
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH

`define CLK_PERIOD_NS 4
`define WORD_BITS 8
`define LINE_IDLE 1'b1

// input spike rejection, low supply and higher supplies
`define SPIKE_LOW_NS 100
`define SPIKE_HIGH_NS 50
`define SPIKE_LOW_CYC ((`SPIKE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPIKE_HIGH_CYC ((`SPIKE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// self-timed write cycle, longest time rounds down
`define TWR_MS 5
`define TWR_CYC (`TWR_MS * 1000000 / `CLK_PERIOD_NS)

// master clock rate, least quarter period rounds up
`define SCL_KHZ 400
`define SCL_QTR_CYC ((1000000 + 4 * `SCL_KHZ * `CLK_PERIOD_NS - 1) / (4 * `SCL_KHZ * `CLK_PERIOD_NS))

`define RECOVER_CLKS 9

`endif

// file: common/two_wire_pkg.sv
package two_wire_pkg;

    typedef enum logic [6:0] {
        ST_STANDBY = 7'h01,
        ST_RX = 7'h02,
        ST_RXD = 7'h04,
        ST_ACK = 7'h08,
        ST_TX = 7'h10,
        ST_MACK = 7'h20,
        ST_WRITE = 7'h40
    } dev_state_t;

    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_START = 5'h02,
        M_BYTE = 5'h04,
        M_STOP = 5'h08,
        M_RECOV = 5'h10
    } mst_state_t;

    typedef enum logic [2:0] {
        CMD_START = 3'h0,
        CMD_STOP = 3'h1,
        CMD_WRITE = 3'h2,
        CMD_READ = 3'h3,
        CMD_RECOVER = 3'h4
    } cmd_t;

endpackage

// file: core/eeprom_bus_device.sv
`timescale 1ns/1ps
`include "two_wire_params.svh"
// Function
// - data changes only while the clock is low
// - data edge with clock high is a condition
// - start is falling data; idle until start
// - stop ends transfer and enters standby, or the write cycle after a write
// - words are eight bits, serial, both directions
// - device pulls data low on ninth clock
// - standby at power-up and after finished stop
// - master recovers with at most nine clocks
// - master starts once data reads high
// - write cycle timed from stop, 5 ms
// - spikes under 100/50 ns are rejected
// - master clock at most 400/1000 kHz
module eeprom_bus_device #(
    parameter int unsigned TWR_CYC = `TWR_CYC
) (
    input wire logic clk,
    input wire logic rst,
    two_wire_if.device bus,
    input wire logic low_supply,
    input wire logic addr_match,
    input wire logic [7:0] tx_data,
    output logic standby,
    output logic write_busy,
    output logic read_mode,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_valid,
    output logic tx_load,
    output logic start_seen,
    output logic stop_seen,
    output logic write_start
);
    import two_wire_pkg::*;

    localparam int TW = $clog2(TWR_CYC + 1);

    // bit 0 clock, bit 1 data, bit 2 supply strap
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [1:0] filt;
    logic [1:0] prev_r;
    logic [4:0] spike_cyc;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    dev_state_t state_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r;
    logic first_r;
    logic read_r;
    logic wr_pend_r;
    logic mack_r;
    logic drv_r;
    logic [TW-1:0] twr_cnt_r;
    logic twr_done;
    logic load_ev;
    logic [7:0] rx_data_r;
    logic rx_first_r;
    logic rx_valid_r;
    logic start_seen_r;
    logic stop_seen_r;
    logic write_start_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 3'h3;
            sync_r <= 3'h3;
        end else begin
            meta_r <= {low_supply, bus.sda_line, bus.scl_line};
            sync_r <= meta_r;
        end
    end

    // the low supply is slower, so it needs the wider window
    assign spike_cyc = sync_r[2] ? 5'(`SPIKE_LOW_CYC) : 5'(`SPIKE_HIGH_CYC);

    // a new level must hold a full window before it is believed
    generate
        for (genvar i = 0; i < 2; i++) begin : g_flt
            logic [4:0] cnt_r;
            logic lvl_r;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt_r <= 5'h00;
                    lvl_r <= `LINE_IDLE;
                end else if (sync_r[i] == lvl_r) begin
                    cnt_r <= 5'h00;
                end else if (cnt_r >= spike_cyc - 5'h01) begin
                    cnt_r <= 5'h00;
                    lvl_r <= sync_r[i];
                end else begin
                    cnt_r <= cnt_r + 5'h01;
                end
            end
            assign filt[i] = lvl_r;
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 2'h3;
        end else begin
            prev_r <= filt;
        end
    end

    assign scl = filt[0];
    assign sda = filt[1];
    assign scl_rise = scl & ~prev_r[0];
    assign scl_fall = ~scl & prev_r[0];
    // any data edge while the clock stays high is a condition, never data
    assign start_det = scl & prev_r[0] & prev_r[1] & ~sda;
    assign stop_det = scl & prev_r[0] & ~prev_r[1] & sda;

    // next read byte is taken from the user on the falling edge
    assign load_ev = scl_fall & ((state_r == ST_ACK & read_r) | (state_r == ST_MACK & mack_r));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_STANDBY;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            first_r <= 1'b0;
            read_r <= 1'b0;
            wr_pend_r <= 1'b0;
            mack_r <= 1'b0;
            drv_r <= 1'b0;
        end else begin
            case (state_r)
                ST_WRITE: begin
                    // inputs are deaf until the cell write has finished
                    if (twr_done) begin
                        state_r <= ST_STANDBY;
                        wr_pend_r <= 1'b0;
                    end
                end
                default: begin
                    if (start_det) begin
                        state_r <= ST_RX;
                        bit_r <= 3'h0;
                        first_r <= 1'b1;
                        read_r <= 1'b0;
                        wr_pend_r <= 1'b0;
                        drv_r <= 1'b0;
                    end else if (stop_det) begin
                        drv_r <= 1'b0;
                        state_r <= wr_pend_r ? ST_WRITE : ST_STANDBY;
                    end else begin
                        case (state_r)
                            ST_RX: if (scl_rise) begin
                                shift_r <= {shift_r[6:0], sda};
                                bit_r <= bit_r + 3'h1;
                                if (bit_r == 3'(`WORD_BITS - 1)) begin
                                    state_r <= ST_RXD;
                                end
                            end
                            ST_RXD: if (scl_fall) begin
                                if (first_r & ~addr_match) begin
                                    state_r <= ST_STANDBY;
                                end else begin
                                    drv_r <= 1'b1;
                                    state_r <= ST_ACK;
                                    if (first_r) begin
                                        read_r <= shift_r[0];
                                    end else begin
                                        wr_pend_r <= 1'b1;
                                    end
                                end
                            end
                            ST_ACK: if (scl_fall) begin
                                first_r <= 1'b0;
                                bit_r <= 3'h0;
                                if (read_r) begin
                                    state_r <= ST_TX;
                                    shift_r <= tx_data;
                                    drv_r <= ~tx_data[7];
                                end else begin
                                    state_r <= ST_RX;
                                    drv_r <= 1'b0;
                                end
                            end
                            ST_TX: if (scl_fall) begin
                                bit_r <= bit_r + 3'h1;
                                if (bit_r == 3'(`WORD_BITS - 1)) begin
                                    drv_r <= 1'b0;
                                    state_r <= ST_MACK;
                                end else begin
                                    shift_r <= {shift_r[6:0], 1'b0};
                                    drv_r <= ~shift_r[6];
                                end
                            end
                            ST_MACK: begin
                                if (scl_rise) begin
                                    mack_r <= ~sda;
                                end
                                if (scl_fall) begin
                                    bit_r <= 3'h0;
                                    if (mack_r) begin
                                        state_r <= ST_TX;
                                        shift_r <= tx_data;
                                        drv_r <= ~tx_data[7];
                                    end else begin
                                        // no acknowledge: read is over, wait for stop
                                        state_r <= ST_STANDBY;
                                    end
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            twr_cnt_r <= '0;
        end else if (state_r != ST_WRITE) begin
            twr_cnt_r <= '0;
        end else begin
            twr_cnt_r <= twr_cnt_r + TW'(1);
        end
    end
    assign twr_done = (twr_cnt_r == TW'(TWR_CYC - 1));

    // received word is shown at its eighth rising edge, so the user
    // has the rest of the clock high time, up to the falling edge, to decide on addr_match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_data_r <= 8'h00;
            rx_first_r <= 1'b0;
            rx_valid_r <= 1'b0;
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
            write_start_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (state_r == ST_RX && scl_rise && bit_r == 3'(`WORD_BITS - 1) && !start_det) begin
                rx_valid_r <= 1'b1;
                rx_data_r <= {shift_r[6:0], sda};
                rx_first_r <= first_r;
            end
            start_seen_r <= start_det & (state_r != ST_WRITE);
            stop_seen_r <= stop_det & (state_r != ST_WRITE);
            write_start_r <= stop_det & wr_pend_r & (state_r != ST_WRITE);
        end
    end

    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe_n = ~drv_r;
    assign standby = (state_r == ST_STANDBY);
    assign write_busy = (state_r == ST_WRITE);
    assign read_mode = read_r;
    assign rx_data = rx_data_r;
    assign rx_first = rx_first_r;
    assign rx_valid = rx_valid_r;
    assign tx_load = load_ev;
    assign start_seen = start_seen_r;
    assign stop_seen = stop_seen_r;
    assign write_start = write_start_r;
endmodule

// file: core/eeprom_bus_master.sv
`timescale 1ns/1ps
`include "two_wire_params.svh"
module eeprom_bus_master (
    input wire logic clk,
    input wire logic rst,
    two_wire_if.master bus,
    input wire logic cmd_valid,
    input wire two_wire_pkg::cmd_t cmd,
    input wire logic [7:0] wdata,
    input wire logic ack_out,
    output logic cmd_ready,
    output logic [7:0] rdata,
    output logic ack_seen,
    output logic done
);
    import two_wire_pkg::*;

    mst_state_t state_r;
    logic [7:0] qcnt_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r;
    logic rd_r;
    logic ack_out_r;
    logic scl_low_r;
    logic sda_low_r;
    logic sda_meta_r;
    logic sda_sync_r;
    logic ack_r;
    logic done_r;
    logic [7:0] rdata_r;
    logic tick;

    assign tick = (state_r != M_IDLE) && (qcnt_r == 8'(`SCL_QTR_CYC - 1));
    assign cmd_ready = (state_r == M_IDLE);
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe_n = ~scl_low_r;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = ~sda_low_r;
    assign rdata = rdata_r;
    assign ack_seen = ack_r;
    assign done = done_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_meta_r <= `LINE_IDLE;
            sda_sync_r <= `LINE_IDLE;
        end else begin
            sda_meta_r <= bus.sda_line;
            sda_sync_r <= sda_meta_r;
        end
    end

    // quarter-period divider, times every bus clock edge except the clock fall when a command is accepted in idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qcnt_r <= 8'h00;
        end else if (tick || state_r == M_IDLE) begin
            qcnt_r <= 8'h00;
        end else begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= M_IDLE;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            rd_r <= 1'b0;
            ack_out_r <= 1'b0;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            ack_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            if (tick) begin
                q_r <= q_r + 2'h1;
            end
            case (state_r)
                M_IDLE: begin
                    q_r <= 2'h0;
                    bit_r <= 4'h0;
                    if (cmd_valid) begin
                        shift_r <= wdata;
                        rd_r <= (cmd == CMD_READ);
                        ack_out_r <= ack_out;
                        case (cmd)
                            CMD_START: begin
                                state_r <= M_START;
                                sda_low_r <= 1'b0;
                            end
                            CMD_STOP: begin
                                state_r <= M_STOP;
                                scl_low_r <= 1'b1;
                            end
                            CMD_RECOVER: begin
                                state_r <= M_RECOV;
                                sda_low_r <= 1'b0;
                                scl_low_r <= 1'b1;
                            end
                            default: begin
                                state_r <= M_BYTE;
                                scl_low_r <= 1'b1;
                            end
                        endcase
                    end
                end
                M_START: if (tick) begin
                    case (q_r)
                        2'h0: begin
                            // a repeated start holds the clock low one more
                            // quarter, else its period falls under the limit
                            if (scl_low_r && bit_r == 4'h0) begin
                                q_r <= 2'h0;
                                bit_r <= 4'h1;
                            end else begin
                                scl_low_r <= 1'b0;
                            end
                        end
                        2'h1: sda_low_r <= 1'b1;
                        2'h3: begin
                            scl_low_r <= 1'b1;
                            state_r <= M_IDLE;
                            done_r <= 1'b1;
                        end
                        default: ;
                    endcase
                end
                M_STOP: if (tick) begin
                    case (q_r)
                        2'h0: sda_low_r <= 1'b1;
                        2'h1: scl_low_r <= 1'b0;
                        2'h2: sda_low_r <= 1'b0;
                        default: begin
                            state_r <= M_IDLE;
                            done_r <= 1'b1;
                        end
                    endcase
                end
                M_BYTE: if (tick) begin
                    case (q_r)
                        2'h0: begin
                            // data moves only in the low half of the clock
                            if (bit_r < 4'(`WORD_BITS)) begin
                                sda_low_r <= ~rd_r & ~shift_r[7];
                            end else begin
                                sda_low_r <= rd_r & ack_out_r;
                            end
                        end
                        2'h1: scl_low_r <= 1'b0;
                        2'h2: begin
                            if (bit_r < 4'(`WORD_BITS)) begin
                                shift_r <= {shift_r[6:0], sda_sync_r};
                            end else begin
                                ack_r <= ~sda_sync_r;
                            end
                        end
                        default: begin
                            scl_low_r <= 1'b1;
                            bit_r <= bit_r + 4'h1;
                            // next slot belongs to the far end: let go with the
                            // clock fall so both ends never pull data at once
                            if (bit_r >= 4'(`WORD_BITS - 1)) begin
                                sda_low_r <= 1'b0;
                            end
                            if (bit_r == 4'(`WORD_BITS)) begin
                                state_r <= M_IDLE;
                                rdata_r <= shift_r;
                                done_r <= 1'b1;
                            end
                        end
                    endcase
                end
                M_RECOV: if (tick) begin
                    case (q_r)
                        2'h1: scl_low_r <= 1'b0;
                        2'h2: begin
                            if (sda_sync_r) begin
                                state_r <= M_START;
                                q_r <= 2'h1;
                                ack_r <= 1'b1;
                            end
                        end
                        2'h3: begin
                            scl_low_r <= 1'b1;
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == 4'(`RECOVER_CLKS - 1)) begin
                                state_r <= M_IDLE;
                                ack_r <= 1'b0;
                                done_r <= 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end
endmodule

// file: testbench/eeprom_serial_bus_conditions_test.sv
`timescale 1ns/1ps
module test_eeprom_serial_bus_conditions;
    import two_wire_pkg::*;
    localparam int TWR = 8000;
    logic clk, rst, cmd_valid, ack_out, cmd_ready, ack_seen, done;
    logic low_supply, addr_match, standby, write_busy, read_mode, rx_first, rx_valid;
    logic tx_load, start_seen, stop_seen, write_start, first_last, ld_cnt;
    logic [7:0] wdata, rdata, tx_data, rx_data, rx_last, start_cnt, ws_cnt, stop_cnt;
    cmd_t cmd;
    int error_cnt = 0, n_checks = 0, cyc = 0, last_n = 0, busy_cnt = 0;

    two_wire_if bus_if();
    eeprom_bus_master eeprom_bus_master_inst (.clk(clk), .rst(rst), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd(cmd), .wdata(wdata), .ack_out(ack_out),
        .cmd_ready(cmd_ready), .rdata(rdata), .ack_seen(ack_seen), .done(done));
    eeprom_bus_device #(.TWR_CYC(TWR)) eeprom_bus_device_inst (.clk(clk), .rst(rst),
        .bus(bus_if), .low_supply(low_supply), .addr_match(addr_match), .tx_data(tx_data),
        .standby(standby), .write_busy(write_busy), .read_mode(read_mode),
        .rx_data(rx_data), .rx_first(rx_first), .rx_valid(rx_valid), .tx_load(tx_load),
        .start_seen(start_seen), .stop_seen(stop_seen), .write_start(write_start));
    two_wire_props two_wire_props_inst (.clk(clk), .rst(rst), .scl_o(bus_if.scl_o),
        .scl_oe_n(bus_if.scl_oe_n), .m_sda_o(bus_if.m_sda_o),
        .m_sda_oe_n(bus_if.m_sda_oe_n), .d_sda_o(bus_if.d_sda_o),
        .d_sda_oe_n(bus_if.d_sda_oe_n), .scl_line(bus_if.scl_line),
        .sda_line(bus_if.sda_line));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // observed device events
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            start_cnt <= 8'h00;
            ws_cnt <= 8'h00;
            stop_cnt <= 8'h00;
            ld_cnt <= 1'b0;
            rx_last <= 8'h00;
            first_last <= 1'b0;
        end else begin
            if (start_seen) start_cnt <= start_cnt + 8'h01;
            if (write_start) ws_cnt <= ws_cnt + 8'h01;
            if (stop_seen) stop_cnt <= stop_cnt + 8'h01;
            if (tx_load) ld_cnt <= 1'b1;
            if (write_busy) busy_cnt <= busy_cnt + 1;
            if (rx_valid) begin
                rx_last <= rx_data;
                first_last <= rx_first;
            end
        end
    end

    // next byte is ready before the device asks for it
    always @(negedge clk) tx_data <= ld_cnt ? 8'h3c : 8'hc3;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("ERROR at %0t: run timed out", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_cmd(input cmd_t c, input logic [7:0] d, input logic ak);
        int n;
        n = 0;
        @(negedge clk);
        cmd = c;
        wdata = d;
        ack_out = ak;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 8000) begin
            error_cnt++;
            $display("ERROR at %0t: command never finished", $time);
        end
        last_n = n;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = CMD_START;
        wdata = 8'h00;
        ack_out = 1'b0;
        low_supply = 1'b1;
        addr_match = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk({7'h0, standby}, 8'h01);
        idle(50);
        // byte write, then polling while the write cycle runs
        do_cmd(CMD_START, 8'h00, 1'b0);
        chk(start_cnt, 8'h01);
        do_cmd(CMD_WRITE, 8'ha0, 1'b0);
        chk({7'h0, ack_seen}, 8'h01);
        chk({first_last, rx_last[6:0]}, {1'b1, 7'h20});
        do_cmd(CMD_WRITE, 8'h5a, 1'b0);
        chk({ack_seen, first_last, 6'h0}, 8'h80);
        chk(rx_last, 8'h5a);
        do_cmd(CMD_STOP, 8'h00, 1'b0);
        idle(40);
        chk({ws_cnt[6:0], write_busy}, 8'h03);
        do_cmd(CMD_START, 8'h00, 1'b0);
        do_cmd(CMD_WRITE, 8'ha0, 1'b0);
        chk({7'h0, ack_seen}, 8'h00);
        do_cmd(CMD_STOP, 8'h00, 1'b0);
        while (write_busy === 1'b1 && cyc < 80000) idle(1);
        chk(8'(busy_cnt / 100), 8'(TWR / 100));
        chk({7'h0, standby}, 8'h01);
        // random read, repeated start, sequential byte, no ack at the end
        low_supply = 1'b0;
        do_cmd(CMD_START, 8'h00, 1'b0);
        do_cmd(CMD_WRITE, 8'ha0, 1'b0);
        do_cmd(CMD_WRITE, 8'h00, 1'b0);
        do_cmd(CMD_START, 8'h00, 1'b0);
        do_cmd(CMD_WRITE, 8'ha1, 1'b0);
        chk({ack_seen, first_last, read_mode, 5'h0}, 8'he0);
        do_cmd(CMD_READ, 8'h00, 1'b1);
        chk(rdata, 8'hc3);
        do_cmd(CMD_READ, 8'h00, 1'b0);
        chk(rdata, 8'h3c);
        do_cmd(CMD_STOP, 8'h00, 1'b0);
        idle(40);
        chk({standby, ws_cnt[6:0]}, 8'h81);
        chk(stop_cnt, 8'h02);
        // foreign address gets no acknowledge
        addr_match = 1'b0;
        do_cmd(CMD_START, 8'h00, 1'b0);
        do_cmd(CMD_WRITE, 8'ha4, 1'b0);
        idle(40);
        chk({ack_seen, standby, 6'h0}, 8'h40);
        do_cmd(CMD_STOP, 8'h00, 1'b0);
        // recovery finds a free line on the first clock
        do_cmd(CMD_RECOVER, 8'h00, 1'b0);
        chk({7'h0, ack_seen}, 8'h01);
        chk({7'h0, last_n <= 9 * 628}, 8'h01);
        wrap_up();
    end
endmodule

// file: testbench/two_wire_props.sv
`timescale 1ns/1ps
module two_wire_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic d_sda_o,
    input wire logic d_sda_oe_n,
    input wire logic scl_line,
    input wire logic sda_line
);
    logic [15:0] rise_gap_r;
    logic in_frame_r;
    logic scl_q_r;
    logic sda_q_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_line;
            sda_q_r <= sda_line;
        end
    end

    // saturates so the first rise after reset never looks fast
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_gap_r <= 16'hffff;
        end else if (scl_line && !scl_q_r) begin
            rise_gap_r <= 16'h0000;
        end else if (rise_gap_r != 16'hffff) begin
            rise_gap_r <= rise_gap_r + 16'h0001;
        end
    end

    // pin-level frame: opened by a start, closed by a stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_frame_r <= 1'b0;
        end else if (scl_line && scl_q_r && sda_q_r && !sda_line) begin
            in_frame_r <= 1'b1;
        end else if (scl_line && scl_q_r && !sda_q_r && sda_line) begin
            in_frame_r <= 1'b0;
        end
    end

    dev_low_only_a: assert property (d_sda_o == 1'b0)
        else $error("device drives data high");
    mst_low_only_a: assert property (!m_sda_o && !scl_o)
        else $error("master drives a line high");
    dev_edge_low_a: assert property ($changed(d_sda_oe_n) |-> !scl_line)
        else $error("device data changed while clock high");
    dev_no_cond_a: assert property (scl_line && $past(scl_line) |-> $stable(d_sda_oe_n))
        else $error("device made a bus condition");
    dev_in_frame_a: assert property (!d_sda_oe_n |-> in_frame_r)
        else $error("device drove data outside a frame");
    scl_rate_a: assert property ($rose(scl_line) |-> rise_gap_r >= 16'd624)
        else $error("clock faster than allowed");
    start_hold_a: assert property ($fell(sda_line) && scl_line |-> ##[1:1000] !scl_line)
        else $error("clock not lowered after start");
    no_contention_a: assert property (!d_sda_oe_n |-> m_sda_oe_n)
        else $error("both ends drive data");
    reset_release_a: assert property (disable iff (1'b0)
        rst |-> d_sda_oe_n && m_sda_oe_n && scl_oe_n)
        else $error("line driven during reset");
endmodule
